// [rtl/lfs_supervisor.sv]
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ns
module lfs_supervisor #(
    parameter int FILT_CYCLES = lfs_pkg::FILT_CYCLES_DEF,
    parameter int BLANK_STEP_CYCLES = lfs_pkg::BLANK_STEP_CYCLES_DEF
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic [9:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_txdisable,
    input wire logic i_supply_low_cmp,
    input wire logic i_txpwr_high_cmp,
    input wire logic i_sat_window_cmp,
    input wire logic i_diode_fault_det,
    input wire logic i_rx_below_assert_cmp,
    input wire logic i_rx_above_deassert_cmp,
    input wire logic i_rxlos_pin,
    input wire logic i_shared_pin,
    input wire lfs_pkg::lfs_byte_t i_temp_on_chip,
    input wire lfs_pkg::lfs_byte_t i_external_junction_input,
    input wire logic i_adc_conv_done,
    input wire lfs_pkg::lfs_byte_t i_bias_meas,
    output logic o_txfault,
    output logic o_rxlos_out,
    output logic o_rxlos_oe_n,
    output logic o_laser_shutdown_out,
    output logic o_laser_shutdown_oe_n,
    output lfs_pkg::lfs_drive_t o_bias_drive_out,
    output lfs_pkg::lfs_drive_t o_modulation_drive_out,
    output logic o_laser_on,
    output lfs_pkg::lfs_byte_t o_bias_fault_thr,
    output lfs_pkg::lfs_byte_t o_los_assert_threshold,
    output lfs_pkg::lfs_byte_t o_los_deassert_threshold,
    output lfs_pkg::lfs_byte_t o_temp_report,
    output logic o_high_temp_alarm,
    output logic o_high_temp_warning
);
    import lfs_pkg::*;

    localparam int FW = $clog2(FILT_CYCLES + 1);
    localparam int BW = $clog2(BLANK_STEP_CYCLES + 1);
    localparam logic [FW-1:0] FILT_LAST = FW'(FILT_CYCLES - 1);
    localparam logic [BW-1:0] STEP_LAST = BW'(BLANK_STEP_CYCLES - 1);

    if (FILT_CYCLES < 1 || BLANK_STEP_CYCLES < 1) begin : g_chk
        $error("Filter and blanking counts must be at least one");
    end

    // Pin synchronisers
    localparam int NS = 9;
    logic [NS-1:0] sync1_r;
    logic [NS-1:0] sync2_r;
    logic s_txd, s_sup, s_pwr, s_sat, s_diode, s_below, s_above;
    logic s_rxlos, s_shared;

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {i_txdisable, i_supply_low_cmp, i_txpwr_high_cmp,
                        i_sat_window_cmp, i_diode_fault_det,
                        i_rx_below_assert_cmp, i_rx_above_deassert_cmp,
                        i_rxlos_pin, i_shared_pin};
            sync2_r <= sync1_r;
        end
    end
    assign {s_txd, s_sup, s_pwr, s_sat, s_diode, s_below, s_above,
            s_rxlos, s_shared} = sync2_r;

    // Software registers
    logic soft_transmit_disable_r;
    lfs_cfg1_t cfg1_r;
    lfs_cfg3_t cfg3_r;
    logic [NUM_FLT-1:0] mask_r;
    logic [7:0] blank_r;
    logic [7:0] bias_thr_r;
    logic [7:0] los_assert_r;
    logic [7:0] los_deassert_r;
    logic [7:0] lut_r [LUT_DEPTH];
    logic ack_r;
    logic wr_en;
    logic [31:0] rd_mux;

    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_r;
    assign wr_en = i_avs_write & ack_r;

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (i_avs_read | i_avs_write) & ~ack_r;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            soft_transmit_disable_r <= 1'b0;
            cfg1_r <= '0;
            cfg3_r <= '0;
            mask_r <= MASK_RST;
            blank_r <= BLANK_RST;
            bias_thr_r <= BIAS_THR_RST;
            los_assert_r <= LOS_ASSERT_RST;
            los_deassert_r <= LOS_DEASSERT_RST;
        end else if (wr_en) begin
            unique case (i_avs_address)
                ADDR_CTRL: soft_transmit_disable_r <= i_avs_writedata[CTRL_SOFT_TRANSMIT_DISABLE_BIT];
                ADDR_CFG1: cfg1_r <= i_avs_writedata[$bits(lfs_cfg1_t)-1:0];
                ADDR_CFG3: cfg3_r <= i_avs_writedata[$bits(lfs_cfg3_t)-1:0];
                ADDR_MASK: mask_r <= i_avs_writedata[NUM_FLT-1:0];
                ADDR_BLANK: blank_r <= i_avs_writedata[7:0];
                ADDR_BIAS_THR: bias_thr_r <= i_avs_writedata[7:0];
                ADDR_LOS_ASSERT: los_assert_r <= i_avs_writedata[7:0];
                ADDR_LOS_DEASSERT: los_deassert_r <= i_avs_writedata[7:0];
                default: soft_transmit_disable_r <= soft_transmit_disable_r;
            endcase
        end
    end

    // Compensation table storage
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            for (int k = 0; k < LUT_DEPTH; k++) begin
                lut_r[k] <= 8'h00;
            end
        end else if (wr_en && i_avs_address[9:8] == LUT_REGION) begin
            lut_r[i_avs_address[7:2]] <= i_avs_writedata[7:0];
        end
    end

    // Fault filters and latch
    logic [NUM_FLT-1:0] flt_raw;
    logic [NUM_FLT-1:0] flt_filt_r;
    logic fault_r;
    logic diode_fault_r;
    logic first_conv_r;
    logic blank_active;
    logic bias_over;
    logic ext_fault;
    logic fault_any;
    logic shut_req;
    logic laser_on;
    logic [NUM_FLT-1:0] flt_arm;

    assign flt_raw[FLT_SUPPLY] = s_sup;
    assign flt_raw[FLT_BIAS] = bias_over;
    assign flt_raw[FLT_TXPWR] = s_pwr;
    assign flt_raw[FLT_SAT] = s_sat & ~blank_active;
    assign flt_raw[FLT_DIODE] = s_diode & first_conv_r & ~s_txd;
    // Filter output lags turn-on, so blank the latch input as well
    assign flt_arm = flt_filt_r & ~mask_r
                   & ~(NUM_FLT'(blank_active) << FLT_SAT);

    for (genvar g = 0; g < NUM_FLT; g++) begin : g_filt
        logic [FW-1:0] cnt_r;
        always_ff @(posedge i_ref_clk) begin
            if (!i_reset_n) begin
                cnt_r <= '0;
                flt_filt_r[g] <= 1'b0;
            end else if (g == FLT_DIODE) begin
                cnt_r <= '0;
                flt_filt_r[g] <= flt_raw[g];
            end else begin
                if (!flt_raw[g]) begin
                    cnt_r <= '0;
                end else if (cnt_r != FILT_LAST) begin
                    cnt_r <= cnt_r + 1'b1;
                end
                flt_filt_r[g] <= flt_raw[g] && cnt_r == FILT_LAST;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            fault_r <= 1'b0;
        end else if (s_txd) begin
            fault_r <= 1'b0;
        end else if (|flt_arm) begin
            fault_r <= 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            diode_fault_r <= 1'b0;
            first_conv_r <= 1'b0;
        end else begin
            first_conv_r <= first_conv_r | i_adc_conv_done;
            if (s_txd) begin
                diode_fault_r <= 1'b0;
            end else if (flt_filt_r[FLT_DIODE]) begin
                diode_fault_r <= 1'b1;
            end
        end
    end

    assign ext_fault = cfg3_r.ext_sel
                     & (s_shared == cfg3_r.ext_pol);
    assign fault_any = fault_r | ext_fault;
    assign shut_req = s_txd | soft_transmit_disable_r | fault_any;
    assign laser_on = cfg1_r.output_en & ~shut_req;

    // Saturation blanking after turn-on
    logic laser_on_d_r;
    logic [7:0] step_cnt_r;
    logic [BW-1:0] pre_r;

    assign blank_active = (laser_on & ~laser_on_d_r) | (step_cnt_r != 8'h00);

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            laser_on_d_r <= 1'b0;
            step_cnt_r <= 8'h00;
            pre_r <= '0;
        end else begin
            laser_on_d_r <= laser_on;
            if (!laser_on) begin
                step_cnt_r <= 8'h00;
                pre_r <= '0;
            end else if (!laser_on_d_r) begin
                step_cnt_r <= blank_r;
                pre_r <= '0;
            end else if (step_cnt_r != 8'h00) begin
                if (pre_r == STEP_LAST) begin
                    pre_r <= '0;
                    step_cnt_r <= step_cnt_r - 8'h01;
                end else begin
                    pre_r <= pre_r + 1'b1;
                end
            end
        end
    end

    // Temperature and bias threshold compensation
    logic [7:0] temp_sel_r;
    logic [7:0] temp_rep;
    logic [5:0] lut_idx;
    logic signed [9:0] thr_sum;
    logic [7:0] thr_comp_r;

    assign temp_rep = diode_fault_r ? TEMP_FULL_SCALE : temp_sel_r;
    assign lut_idx = temp_rep[7] ? 6'h00 : temp_rep[6:1];
    assign thr_sum = $signed({2'b00, bias_thr_r})
                   + $signed({{2{lut_r[lut_idx][7]}}, lut_r[lut_idx]});
    assign bias_over = i_bias_meas > thr_comp_r;

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            temp_sel_r <= 8'h00;
            thr_comp_r <= BIAS_THR_RST;
        end else begin
            temp_sel_r <= cfg1_r.sensor_sel ? i_external_junction_input
                                            : i_temp_on_chip;
            if (thr_sum < 0) begin
                thr_comp_r <= 8'h00;
            end else if (thr_sum > 10'sd255) begin
                thr_comp_r <= 8'hff;
            end else begin
                thr_comp_r <= thr_sum[7:0];
            end
        end
    end

    // Loss of signal with hysteresis
    logic los_r;

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            los_r <= 1'b0;
        end else if (s_below) begin
            los_r <= 1'b1;
        end else if (s_above) begin
            los_r <= 1'b0;
        end
    end

    // Output stage
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            o_txfault <= 1'b0;
            o_rxlos_out <= 1'b0;
            o_rxlos_oe_n <= 1'b1;
            o_laser_shutdown_out <= 1'b0;
            o_laser_shutdown_oe_n <= 1'b1;
            o_bias_drive_out <= '{oe_n: 1'b1, shut: 1'b1, level: 1'b0};
            o_modulation_drive_out <= '{oe_n: 1'b1, shut: 1'b1, level: 1'b0};
            o_laser_on <= 1'b0;
            o_temp_report <= 8'h00;
            o_high_temp_alarm <= 1'b0;
            o_high_temp_warning <= 1'b0;
        end else begin
            o_txfault <= fault_any | diode_fault_r;
            o_rxlos_out <= los_r;
            o_rxlos_oe_n <= cfg3_r.los_dis;
            o_laser_shutdown_out <= shut_req ~^ cfg1_r.shutdown_pol;
            o_laser_shutdown_oe_n <= ~cfg1_r.output_en | cfg3_r.ext_sel;
            o_bias_drive_out.oe_n <= ~cfg1_r.output_en;
            o_bias_drive_out.shut <= shut_req;
            o_bias_drive_out.level <= cfg1_r.bias_ref_sel;
            o_modulation_drive_out.oe_n <= ~cfg1_r.output_en;
            o_modulation_drive_out.shut <= shut_req;
            o_modulation_drive_out.level <= cfg1_r.mod_ref_sel;
            o_laser_on <= laser_on;
            o_temp_report <= temp_rep;
            o_high_temp_alarm <= diode_fault_r;
            o_high_temp_warning <= diode_fault_r;
        end
    end

    assign o_bias_fault_thr = thr_comp_r;
    assign o_los_assert_threshold = los_assert_r;
    assign o_los_deassert_threshold = los_deassert_r;

    // Read data
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (i_avs_address[9:8] == LUT_REGION) begin
            rd_mux[7:0] = lut_r[i_avs_address[7:2]];
        end else begin
            unique case (i_avs_address)
                ADDR_CTRL: begin
                    rd_mux[CTRL_SOFT_TRANSMIT_DISABLE_BIT] = soft_transmit_disable_r;
                    rd_mux[CTRL_TXFAULT_BIT] = fault_any | diode_fault_r;
                    rd_mux[CTRL_RXLOS_BIT] = s_rxlos;
                    rd_mux[CTRL_TXDIS_BIT] = s_txd;
                end
                ADDR_CFG1: begin
                    rd_mux[$bits(lfs_cfg1_t)-1:0] = cfg1_r;
                    rd_mux[CFG1_DIODE_FAULT_FLAG_BIT] = diode_fault_r;
                end
                ADDR_CFG3: rd_mux[$bits(lfs_cfg3_t)-1:0] = cfg3_r;
                ADDR_MASK: rd_mux[NUM_FLT-1:0] = mask_r;
                ADDR_BLANK: rd_mux[7:0] = blank_r;
                ADDR_BIAS_THR: rd_mux[7:0] = bias_thr_r;
                ADDR_TEMP: rd_mux[7:0] = temp_rep;
                ADDR_FLT_RAW: rd_mux[NUM_FLT-1:0] = flt_filt_r;
                ADDR_LOS_ASSERT: rd_mux[7:0] = los_assert_r;
                ADDR_LOS_DEASSERT: rd_mux[7:0] = los_deassert_r;
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (i_avs_read && !ack_r) begin
            o_avs_readdata <= rd_mux;
        end
    end

    // Checks
    a_txfault_follow: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        fault_any |=> o_txfault)
        else $error("TXFAULT missed a fault");
    a_mask_blocks: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        (&mask_r) && !fault_r |=> !fault_r)
        else $error("Masked source latched a fault");
    a_blank_start: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        $rose(laser_on) |-> blank_active ##1 (step_cnt_r == blank_r))
        else $error("Blanking not started at turn-on");
    a_los_assert: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        s_below |=> los_r ##1 o_rxlos_out)
        else $error("RXLOS not raised below threshold");
    a_los_hold: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        los_r && !s_above |=> los_r)
        else $error("RXLOS dropped without deassert level");
    a_filter_glitch: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        !s_sup |=> !flt_filt_r[FLT_SUPPLY])
        else $error("Supply glitch passed the filter");
    a_diode_temp: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        diode_fault_r |=> o_temp_report == TEMP_FULL_SCALE)
        else $error("Temperature not forced to full scale");
    a_txd_clears: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        s_txd |=> !fault_r && !diode_fault_r)
        else $error("Fault survived TXDISABLE");
    a_diode_inhibit: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        !first_conv_r |-> !diode_fault_r)
        else $error("Diode fault before first conversion");
    a_laser_shutdown_out_pol: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        cfg1_r.output_en && !cfg3_r.ext_sel && shut_req |=>
        !o_laser_shutdown_oe_n
        && o_laser_shutdown_out == $past(cfg1_r.shutdown_pol))
        else $error("Shutdown output wrong level");

endmodule

// [shared/lfs_pkg.sv]
package lfs_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int FILT_TIME_NS = 10_000_000;
    localparam int FILT_CYCLES_DEF =
        (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLANK_STEP_NS = 500_000;
    localparam int BLANK_STEP_CYCLES_DEF =
        (BLANK_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Register byte addresses
    localparam logic [9:0] ADDR_CTRL = 10'h000;
    localparam logic [9:0] ADDR_CFG1 = 10'h004;
    localparam logic [9:0] ADDR_CFG3 = 10'h008;
    localparam logic [9:0] ADDR_MASK = 10'h00c;
    localparam logic [9:0] ADDR_BLANK = 10'h010;
    localparam logic [9:0] ADDR_BIAS_THR = 10'h014;
    localparam logic [9:0] ADDR_TEMP = 10'h018;
    localparam logic [9:0] ADDR_FLT_RAW = 10'h01c;
    localparam logic [9:0] ADDR_LOS_ASSERT = 10'h020;
    localparam logic [9:0] ADDR_LOS_DEASSERT = 10'h024;
    localparam logic [1:0] LUT_REGION = 2'h1;
    localparam int LUT_DEPTH = 64;

    // Control and CFG1 register fields
    localparam int CTRL_SOFT_TRANSMIT_DISABLE_BIT = 0;
    localparam int CTRL_TXFAULT_BIT = 1;
    localparam int CTRL_RXLOS_BIT = 2;
    localparam int CTRL_TXDIS_BIT = 3;
    localparam int CFG1_DIODE_FAULT_FLAG_BIT = 7;

    // Fault source positions
    localparam int FLT_SUPPLY = 0;
    localparam int FLT_DIODE = 1;
    localparam int FLT_BIAS = 2;
    localparam int FLT_TXPWR = 3;
    localparam int FLT_SAT = 4;
    localparam int NUM_FLT = 5;

    // Reset values and full-scale temperature code
    localparam logic [4:0] MASK_RST = 5'h00;
    localparam logic [7:0] BLANK_RST = 8'h01;
    localparam logic [7:0] BIAS_THR_RST = 8'hff;
    localparam logic [7:0] LOS_ASSERT_RST = 8'h00;
    localparam logic [7:0] LOS_DEASSERT_RST = 8'h00;
    localparam logic [7:0] TEMP_FULL_SCALE = 8'h7f;

    typedef logic [7:0] lfs_byte_t;

    typedef struct packed {
        logic sensor_sel;
        logic mod_ref_sel;
        logic bias_ref_sel;
        logic shutdown_pol;
        logic output_en;
    } lfs_cfg1_t;

    typedef struct packed {
        logic los_dis;
        logic ext_pol;
        logic ext_sel;
    } lfs_cfg3_t;

    typedef struct packed {
        logic oe_n;
        logic shut;
        logic level;
    } lfs_drive_t;

endpackage

// [tb/lfs_laser_model.sv]
`timescale 1ns/1ns
module lfs_laser_model (
    input wire logic i_ref_clk,
    input wire logic i_shutdown_out,
    input wire logic i_shutdown_oe_n,
    input wire logic i_rxlos_out,
    input wire logic i_rxlos_oe_n,
    input wire logic i_ext_drive_en,
    input wire logic i_ext_fault_lvl,
    input wire logic i_ext_rxlos_en,
    input wire logic i_ext_rxlos_lvl,
    output logic o_shared_pin,
    output logic o_rxlos_pin
);
    logic float_r = 1'b0;
    always_ff @(posedge i_ref_clk) begin
        float_r <= ~float_r;
    end
    // Driver IC owns the shared pin whenever enabled, even before it is an input
    always_comb begin
        if (i_ext_drive_en) o_shared_pin = i_ext_fault_lvl;
        else if (!i_shutdown_oe_n) o_shared_pin = i_shutdown_out;
        else o_shared_pin = float_r;
    end
    // Receive-loss line with pull-up
    always_comb begin
        if (!i_rxlos_oe_n) o_rxlos_pin = i_rxlos_out;
        else if (i_ext_rxlos_en) o_rxlos_pin = i_ext_rxlos_lvl;
        else o_rxlos_pin = 1'b1;
    end
endmodule

// [tb/lfs_supervisor_tb.sv]
`timescale 1ns/1ns
module lfs_supervisor_tb;
    import lfs_pkg::*;
    localparam int FILT = 4;
    logic clk, rst_n, rd, wr, txdis, diode, below, above, conv;
    logic ext_en, ext_lvl, xr_en, xr_lvl, shared, rxlos_pin;
    logic av_wait, txfault, rx_out, rx_oe_n, sd_out, sd_oe_n;
    logic laser_on, alarm, warn;
    logic [2:0] cmp;
    logic [9:0] addr;
    logic [31:0] wdata, rdv, av_rdata;
    lfs_byte_t t_on, t_ext, temp_rep, bias_thr, bmeas, los_a, los_d;
    lfs_drive_t bias_d, mod_d;
    int failures = 0;
    int compares = 0;
    int pos[3] = '{FLT_SUPPLY, FLT_TXPWR, FLT_SAT};

    lfs_supervisor #(.FILT_CYCLES(FILT), .BLANK_STEP_CYCLES(3)) i_dut (
        .i_ref_clk(clk), .i_reset_n(rst_n), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
        .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait),
        .i_txdisable(txdis), .i_supply_low_cmp(cmp[0]),
        .i_txpwr_high_cmp(cmp[1]), .i_sat_window_cmp(cmp[2]),
        .i_diode_fault_det(diode), .i_rx_below_assert_cmp(below),
        .i_rx_above_deassert_cmp(above), .i_rxlos_pin(rxlos_pin),
        .i_shared_pin(shared), .i_temp_on_chip(t_on),
        .i_external_junction_input(t_ext), .i_adc_conv_done(conv),
        .i_bias_meas(bmeas), .o_txfault(txfault), .o_rxlos_out(rx_out),
        .o_rxlos_oe_n(rx_oe_n), .o_laser_shutdown_out(sd_out),
        .o_laser_shutdown_oe_n(sd_oe_n), .o_bias_drive_out(bias_d),
        .o_modulation_drive_out(mod_d), .o_laser_on(laser_on),
        .o_bias_fault_thr(bias_thr), .o_los_assert_threshold(los_a),
        .o_los_deassert_threshold(los_d), .o_temp_report(temp_rep),
        .o_high_temp_alarm(alarm), .o_high_temp_warning(warn)
    );

    lfs_laser_model i_model (
        .i_ref_clk(clk), .i_shutdown_out(sd_out),
        .i_shutdown_oe_n(sd_oe_n), .i_rxlos_out(rx_out),
        .i_rxlos_oe_n(rx_oe_n), .i_ext_drive_en(ext_en),
        .i_ext_fault_lvl(ext_lvl), .i_ext_rxlos_en(xr_en),
        .i_ext_rxlos_lvl(xr_lvl), .o_shared_pin(shared),
        .o_rxlos_pin(rxlos_pin)
    );

    task automatic wrap_up;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic bus(input logic w, input logic [9:0] a,
                       input logic [31:0] d);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do begin
            @(posedge clk);
        end while (av_wait);
        rdv = av_rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rchk(input logic [9:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rdv, e);
    endtask

    task automatic toggle;
        txdis <= 1'b1;
        cyc(6);
        txdis <= 1'b0;
        cyc(10);
    endtask

    task automatic conv_pulse;
        conv <= 1'b1;
        @(posedge clk);
        conv <= 1'b0;
        cyc(8);
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        wrap_up();
    end

    initial begin
        {rst_n, rd, wr, txdis, diode, below, above, conv} = 8'h00;
        {ext_en, ext_lvl, xr_en, xr_lvl, cmp} = 7'h00;
        addr = 10'h000;
        wdata = 32'h0;
        t_on = 8'h19;
        t_ext = 8'h2a;
        bmeas = 8'h00;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rchk(ADDR_CFG1, 32'h0);
        rchk(ADDR_MASK, 32'h0);
        rchk(ADDR_BLANK, 32'h1);
        rchk(ADDR_BIAS_THR, 32'hff);
        rchk(10'h0f0, 32'h0);
        chk(sd_oe_n, 1'b1);
        chk(bias_d, 32'h4);
        bus(1'b1, ADDR_CFG1, 32'h7);
        cyc(6);
        chk({laser_on, sd_out, sd_oe_n}, 32'h4);
        for (int i = 0; i < 3; i++) begin
            cmp[i] <= 1'b1;
            cyc(FILT + 12);
            chk(txfault, 1'b1);
            chk({sd_out, sd_oe_n, bias_d, mod_d}, 32'h9a);
            rchk(ADDR_FLT_RAW, 32'h1 << pos[i]);
            rchk(ADDR_CTRL, 32'h2);
            cmp[i] <= 1'b0;
            cyc(FILT + 8);
            chk(txfault, 1'b1);
            toggle();
            chk(txfault, 1'b0);
        end
        cmp[0] <= 1'b1;
        cyc(2);
        cmp[0] <= 1'b0;
        cyc(12);
        chk(txfault, 1'b0);
        bus(1'b1, ADDR_MASK, 32'h1f);
        cmp[0] <= 1'b1;
        cyc(FILT + 12);
        chk(txfault, 1'b0);
        rchk(ADDR_FLT_RAW, 32'h1);
        cmp[0] <= 1'b0;
        toggle();
        bus(1'b1, ADDR_MASK, 32'h0);
        bus(1'b1, ADDR_BLANK, 32'h5);
        cmp[2] <= 1'b1;
        txdis <= 1'b1;
        cyc(6);
        txdis <= 1'b0;
        cyc(10);
        chk(txfault, 1'b0);
        cyc(30);
        chk(txfault, 1'b1);
        cmp[2] <= 1'b0;
        toggle();
        bus(1'b1, ADDR_CTRL, 32'h1);
        cyc(6);
        chk({sd_out, laser_on}, 32'h2);
        bus(1'b1, ADDR_CTRL, 32'h0);
        txdis <= 1'b1;
        cyc(6);
        chk(sd_out, 1'b1);
        bus(1'b1, ADDR_CFG1, 32'h5);
        cyc(6);
        chk({sd_out, sd_oe_n}, 32'h0);
        bus(1'b1, ADDR_CFG1, 32'h7);
        txdis <= 1'b0;
        ext_en <= 1'b1;
        bus(1'b1, ADDR_CFG3, 32'h3);
        cyc(6);
        chk({sd_oe_n, txfault}, 32'h2);
        ext_lvl <= 1'b1;
        cyc(8);
        chk(txfault, 1'b1);
        bus(1'b1, ADDR_CFG3, 32'h1);
        cyc(6);
        chk(txfault, 1'b0);
        ext_lvl <= 1'b0;
        cyc(8);
        chk(txfault, 1'b1);
        ext_lvl <= 1'b1;
        bus(1'b1, ADDR_CFG3, 32'h0);
        ext_en <= 1'b0;
        toggle();
        below <= 1'b1;
        cyc(6);
        chk({rx_out, rx_oe_n}, 32'h2);
        below <= 1'b0;
        cyc(6);
        chk(rx_out, 1'b1);
        above <= 1'b1;
        cyc(6);
        chk(rx_out, 1'b0);
        above <= 1'b0;
        bus(1'b1, ADDR_LOS_ASSERT, 32'h33);
        bus(1'b1, ADDR_LOS_DEASSERT, 32'h44);
        chk({los_a, los_d}, 32'h3344);
        xr_en <= 1'b1;
        xr_lvl <= 1'b1;
        bus(1'b1, ADDR_CFG3, 32'h4);
        cyc(6);
        chk(rx_oe_n, 1'b1);
        rchk(ADDR_CTRL, 32'h4);
        xr_lvl <= 1'b0;
        cyc(6);
        rchk(ADDR_CTRL, 32'h0);
        diode <= 1'b1;
        cyc(8);
        chk(txfault, 1'b0);
        conv_pulse();
        chk(temp_rep, 8'h7f);
        chk({alarm, warn, txfault}, 32'h7);
        rchk(ADDR_CFG1, 32'h87);
        txdis <= 1'b1;
        cyc(6);
        chk({alarm, warn}, 32'h0);
        diode <= 1'b0;
        txdis <= 1'b0;
        cyc(6);
        conv_pulse();
        chk(temp_rep, t_on);
        bus(1'b1, 10'h130, 32'hfb);
        bus(1'b1, ADDR_BIAS_THR, 32'h40);
        cyc(8);
        chk(bias_thr, 8'h3b);
        bmeas <= 8'h3c;
        cyc(FILT + 12);
        chk(txfault, 1'b1);
        bmeas <= 8'h00;
        toggle();
        bus(1'b1, ADDR_BIAS_THR, 32'h02);
        cyc(8);
        chk(bias_thr, 8'h00);
        bus(1'b1, ADDR_CFG1, 32'h17);
        conv_pulse();
        chk(temp_rep, t_ext);
        wrap_up();
    end
endmodule
